// ===== shared/drmc_cfg.svh
// Purpose: constants for the strobe-driven 4K x 1 dynamic memory controller
// Assumes: 20 MHz core_clk, 50 ns period
// Notes: times kept in ns, cycle counts derived from them
`ifndef DRMC_CFG_SVH
`define DRMC_CFG_SVH
`define DRMC_CLK_NS      50
`define DRMC_ADDR_W      12
`define DRMC_PIN_W       6
`define DRMC_ROWS        64
`define DRMC_T_RCL_NS    150
`define DRMC_T_CAC_NS    200
`define DRMC_T_CPW_NS    200
`define DRMC_T_WP_NS     200
`define DRMC_T_RP_NS     150
`define DRMC_T_AH_NS     80
`define DRMC_T_RFSH_NS   2000000
`define DRMC_CYC(t)      (((t) + `DRMC_CLK_NS - 1) / `DRMC_CLK_NS)
`define DRMC_CYC_DN(t)   ((t) / `DRMC_CLK_NS)
`endif

// ===== shared/drmc_pkg.sv
// Purpose: types for the dynamic memory controller
// Assumes: constants come from drmc_cfg.svh
// Notes: request and pin groups travel as packed structs
`include "drmc_cfg.svh"
package drmc_pkg;
   typedef enum logic [1:0] {
      drmc_op_read  = 2'h0,
      drmc_op_write = 2'h1,
      drmc_op_rmw   = 2'h2
   } drmc_op_t;

   typedef struct packed {
      drmc_op_t                  op;
      logic [`DRMC_ADDR_W-1:0]  addr;
      logic                      wdata;
      logic                      cs_n;
   } drmc_req_t;

   typedef struct packed {
      logic                      ras_n;
      logic                      cas_n;
      logic                      we_n;
      logic                      cs_n;
      logic                      din;
      logic [`DRMC_PIN_W-1:0]   multiplexed_addr_pins;
   } drmc_pins_t;

   typedef enum logic [7:0] {
      drmc_st_idle = 8'h01,
      drmc_st_row  = 8'h02,
      drmc_st_col  = 8'h04,
      drmc_st_acc  = 8'h08,
      drmc_st_wr   = 8'h10,
      drmc_st_hold = 8'h20,
      drmc_st_pre  = 8'h40,
      drmc_st_ref  = 8'h80
   } drmc_state_t;
endpackage

// ===== rtl/drmc_ctrl.sv
// Purpose: controller that drives a 4K x 1 strobe-paced dynamic memory
// Assumes: dout pin sampled synchronously; one request at a time
// Notes: refresh takes priority over a waiting user request
`include "drmc_cfg.svh"
// Overview of operation
// - Address goes out as row half then column half on six pins.
// - Early write: write enable falls before column strobe; data held around it.
// - Read-modify-write: write enable stays high until access time passes.
// - Every one of 64 rows gets a cycle within each 2 ms.
// - Refresh cycles run with chip deselected so no cell is written.
// - Column strobe goes to every chip; row strobe on every cycle, refresh cycles included.
// - Chip select may be held low when row strobe selects the chip.
module drmc_ctrl #(
   parameter int unsigned REFRESH_NS = `DRMC_T_RFSH_NS
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  wire drmc_pkg::drmc_req_t      req,
   input  wire logic                     rmw_wdata,
   output logic                          rsp_valid,
   output logic                          rsp_data,
   output logic                          rsp_selected,
   output drmc_pkg::drmc_pins_t          pins,
   input  wire logic                     dout
);
   localparam int unsigned RCL_C = `DRMC_CYC(`DRMC_T_RCL_NS);
   localparam int unsigned CAC_C = `DRMC_CYC(`DRMC_T_CAC_NS);
   localparam int unsigned WP_C  = `DRMC_CYC(`DRMC_T_WP_NS);
   localparam int unsigned RP_C  = `DRMC_CYC(`DRMC_T_RP_NS);
   localparam int unsigned AH_C  = `DRMC_CYC(`DRMC_T_AH_NS);
   // Spread 64 rows evenly across the period, rounding down to stay safe
   localparam int unsigned REF_C = (REFRESH_NS / `DRMC_ROWS) / `DRMC_CLK_NS;

   drmc_pkg::drmc_state_t  state;
   drmc_pkg::drmc_state_t  next_state;
   drmc_pkg::drmc_req_t    cur;
   logic [15:0]            tmr;
   logic [15:0]            ref_tmr;
   logic                   ref_due;
   logic [5:0]             ref_row;
   logic                   is_ref;
   logic                   sel;

   wire logic tmr_done   = (tmr == 16'h0000);
   wire logic ref_expire = (ref_tmr == 16'h0000);
   wire logic start_ref  = (state == drmc_pkg::drmc_st_idle) && ref_due;
   wire logic start_req  = (state == drmc_pkg::drmc_st_idle) && !ref_due && req_valid;
   wire logic cur_early  = (cur.op == drmc_pkg::drmc_op_write);
   wire logic cur_rmw    = (cur.op == drmc_pkg::drmc_op_rmw);

   assign req_ready = (state == drmc_pkg::drmc_st_idle) && !ref_due;

   function automatic logic [15:0] cyc16(input int unsigned n);
      cyc16 = n[15:0] - 16'h0001;
   endfunction

   always_comb begin
      next_state = state;
      unique case (state)
         drmc_pkg::drmc_st_idle: begin
            if (ref_due || req_valid) begin
               next_state = drmc_pkg::drmc_st_row;
            end
         end
         drmc_pkg::drmc_st_row: begin
            if (tmr_done) begin
               next_state = drmc_pkg::drmc_st_col;
            end
         end
         drmc_pkg::drmc_st_col: begin
            if (tmr_done) begin
               next_state = drmc_pkg::drmc_st_acc;
            end
         end
         drmc_pkg::drmc_st_acc: begin
            if (tmr_done) begin
               next_state = cur_rmw ? drmc_pkg::drmc_st_wr : drmc_pkg::drmc_st_hold;
            end
         end
         drmc_pkg::drmc_st_wr: begin
            if (tmr_done) begin
               next_state = drmc_pkg::drmc_st_hold;
            end
         end
         drmc_pkg::drmc_st_hold: begin
            next_state = drmc_pkg::drmc_st_pre;
         end
         drmc_pkg::drmc_st_pre: begin
            if (tmr_done) begin
               next_state = drmc_pkg::drmc_st_idle;
            end
         end
         default: begin
            next_state = drmc_pkg::drmc_st_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state <= drmc_pkg::drmc_st_idle;
      end else begin
         state <= next_state;
      end
   end

   // Per-state dwell counter
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tmr <= 16'h0000;
      end else if (next_state != state) begin
         unique case (next_state)
            drmc_pkg::drmc_st_row:  tmr <= cyc16(RCL_C);
            drmc_pkg::drmc_st_col:  tmr <= cyc16(AH_C);
            drmc_pkg::drmc_st_acc:  tmr <= cyc16(CAC_C);
            drmc_pkg::drmc_st_wr:   tmr <= cyc16(WP_C);
            drmc_pkg::drmc_st_pre:  tmr <= cyc16(RP_C);
            default:                tmr <= 16'h0000;
         endcase
      end else if (!tmr_done) begin
         tmr <= tmr - 16'h0001;
      end
   end

   // Refresh pacing; a due flag set by expiry wins over the clear
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ref_tmr <= 16'h0000;
         ref_due <= 1'b0;
         ref_row <= 6'h00;
      end else begin
         ref_tmr <= ref_expire ? cyc16(REF_C) : ref_tmr - 16'h0001;
         if (ref_expire) begin
            ref_due <= 1'b1;
         end else if (start_ref) begin
            ref_due <= 1'b0;
         end
         if (start_ref) begin
            ref_row <= ref_row + 6'h01;
         end
      end
   end

   // Capture request; refresh is a deselected read
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur    <= '0;
         is_ref <= 1'b0;
      end else if (start_ref) begin
         cur.op    <= drmc_pkg::drmc_op_read;
         cur.addr  <= {ref_row, 6'h00};
         cur.wdata <= 1'b0;
         cur.cs_n  <= 1'b1;
         is_ref    <= 1'b1;
      end else if (start_req) begin
         cur    <= req;
         is_ref <= 1'b0;
      end else if (state == drmc_pkg::drmc_st_acc && tmr_done && cur_rmw) begin
         cur.wdata <= rmw_wdata;
      end
   end

   assign sel = !cur.cs_n;

   // Pin drive: all from flops; column strobe shared by every chip
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pins <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, cs_n: 1'b1,
                   din: 1'b0, multiplexed_addr_pins: 6'h00};
      end else begin
         unique case (next_state)
            drmc_pkg::drmc_st_row: begin
               pins.multiplexed_addr_pins <= cur_next_row();
               pins.ras_n <= (state == drmc_pkg::drmc_st_idle) ? 1'b1 : 1'b0;
            end
            drmc_pkg::drmc_st_col: begin
               pins.multiplexed_addr_pins <= cur.addr[5:0];
               pins.cs_n  <= cur.cs_n;
               pins.din   <= cur.wdata;
               pins.we_n  <= !cur_early;
            end
            drmc_pkg::drmc_st_acc: begin
               pins.cas_n <= 1'b0;
            end
            drmc_pkg::drmc_st_wr: begin
               // Data first, write enable a cycle later, so din never moves with it
               pins.din  <= (state == drmc_pkg::drmc_st_wr) ? cur.wdata : rmw_wdata;
               pins.we_n <= (state != drmc_pkg::drmc_st_wr);
            end
            drmc_pkg::drmc_st_hold: begin
               pins.cas_n <= 1'b0;
            end
            drmc_pkg::drmc_st_pre, drmc_pkg::drmc_st_idle: begin
               pins.ras_n <= 1'b1;
               pins.cas_n <= 1'b1;
               pins.we_n  <= 1'b1;
            end
            default: begin
               pins.ras_n <= 1'b1;
            end
         endcase
      end
   end

   // Row strobe falls one cycle after row address is set up
   function automatic logic [5:0] cur_next_row();
      cur_next_row = (state == drmc_pkg::drmc_st_idle) ?
                     (ref_due ? ref_row : req.addr[11:6]) : cur.addr[11:6];
   endfunction

   // Read bit sampled after access time; deselected reads flag no data
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rsp_valid    <= 1'b0;
         rsp_data     <= 1'b0;
         rsp_selected <= 1'b0;
      end else begin
         rsp_valid <= state == drmc_pkg::drmc_st_acc && tmr_done && !is_ref;
         // Refresh leaves the last answer standing
         if (state == drmc_pkg::drmc_st_acc && tmr_done && !is_ref) begin
            rsp_data     <= sel ? dout : 1'b1;
            rsp_selected <= sel;
         end
      end
   end
endmodule

// ===== verif/drmc_monitor.sv
// Purpose: pin timing checks for the memory controller
// Assumes: 50 ns clock; REFRESH_NS as on the design
// Notes: strobe timings counted in whole clock cycles
module drmc_monitor #(
   parameter int unsigned REFRESH_NS = 2000000
) (
   input wire logic                 core_clk,
   input wire logic                 rst,
   input wire logic                 req_valid,
   input wire logic                 req_ready,
   input wire drmc_pkg::drmc_req_t  req,
   input wire logic                 rmw_wdata,
   input wire logic                 rsp_valid,
   input wire logic                 rsp_data,
   input wire logic                 rsp_selected,
   input wire drmc_pkg::drmc_pins_t pins,
   input wire logic                 dout
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Slack of 20 cycles covers one user cycle ahead of a due refresh
   localparam int unsigned LIM = REFRESH_NS / 3200 + 20;
   logic [15:0] gap;
   always_ff @(posedge core_clk or posedge rst)
      if (rst) gap <= 16'h0000;
      else gap <= pins.ras_n ? gap + 16'h0001 : 16'h0000;
   a_row_addr_held:
      assert property ($fell(pins.ras_n) |-> $stable(pins.multiplexed_addr_pins))
      else $error("row address moved at row strobe");
   a_col_cs_held:
      assert property ($fell(pins.cas_n) |->
         !pins.ras_n && $stable({pins.multiplexed_addr_pins, pins.cs_n}))
      else $error("column strobe bad");
   a_row_col_lead:
      assert property ($fell(pins.ras_n) |-> pins.cas_n [*3])
      else $error("column strobe too early");
   a_din_hold:
      assert property (($fell(pins.cas_n) && !pins.we_n) || ($fell(pins.we_n) && !pins.cas_n)
         |-> $stable(pins.din) [*3])
      else $error("data in not held");
   a_rmw_we_late:
      assert property ($fell(pins.we_n) && !pins.cas_n |-> !$past(pins.cas_n, 4))
      else $error("write enable before access time");
   a_precharge:
      assert property ($rose(pins.ras_n) |-> (pins.ras_n && pins.cas_n && pins.we_n) [*3])
      else $error("precharge too short");
   a_refresh_gap:
      assert property (gap < LIM)
      else $error("row strobe idle too long");
   a_desel_data:
      assert property (rsp_valid && !rsp_selected |-> rsp_data)
      else $error("deselected answer not one");
   a_access_wait:
      assert property (rsp_valid |-> !$past(pins.cas_n, 4))
      else $error("answer before access time");
   a_busy_not_ready:
      assert property (!pins.ras_n |-> !req_ready)
      else $error("ready during a cycle");
endmodule
bind drmc_ctrl drmc_monitor #(.REFRESH_NS(REFRESH_NS)) u_drmc_monitor (
   .core_clk(core_clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
   .req(req), .rmw_wdata(rmw_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .rsp_selected(rsp_selected), .pins(pins), .dout(dout));

// ===== verif/drmc_mem_model.sv
// Purpose: behavioural 4K x 1 strobe-paced memory
// Assumes: access time below four clock periods
// Notes: undriven output shows the inverted last bit
module drmc_mem_model #(
   parameter int ACC_NS = 150
) (
   input  wire drmc_pkg::drmc_pins_t pins,
   output logic                      dout
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       mem [4096];
   logic [5:0] row;
   logic [5:0] col;
   logic       sel = 1'b0;
   logic       hiz = 1'b1;
   logic       q   = 1'b0;
   always @(negedge pins.ras_n) row = pins.multiplexed_addr_pins;
   always @(negedge pins.cas_n) begin
      col = pins.multiplexed_addr_pins;
      sel = !pins.ras_n && !pins.cs_n;
      hiz = 1'b1;
      if (sel && !pins.we_n) mem[{row, col}] = pins.din;
      #(ACC_NS);
      if (sel) q = !pins.we_n ? 1'b1 : mem[{row, col}];
      hiz = !sel;
   end
   // Small delay lets din settle when it moves with write enable
   always @(negedge pins.we_n) begin
      #1;
      if (sel && !pins.cas_n) mem[{row, col}] = pins.din;
   end
   assign dout = hiz ? ~q : q;
endmodule

// ===== verif/testbench.sv
// Purpose: self-checking bench for the memory controller
// Assumes: refresh period shortened to 200 us
// Notes: inputs driven at the falling clock edge
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam drmc_pkg::drmc_op_t RD = drmc_pkg::drmc_op_read;
   localparam drmc_pkg::drmc_op_t WR = drmc_pkg::drmc_op_write;
   localparam drmc_pkg::drmc_op_t RM = drmc_pkg::drmc_op_rmw;
   logic                 core_clk;
   logic                 rst;
   logic                 req_valid;
   logic                 req_ready;
   drmc_pkg::drmc_req_t  req;
   logic                 rmw_wdata;
   logic                 rsp_valid;
   logic                 rsp_data;
   logic                 rsp_selected;
   drmc_pkg::drmc_pins_t pins;
   logic                 dout;
   int                   n_errors;
   int                   n_tests;
   int                   n_ras;
   drmc_ctrl #(.REFRESH_NS(200000)) u_drmc_ctrl (.core_clk(core_clk), .rst(rst),
      .req_valid(req_valid), .req_ready(req_ready), .req(req), .rmw_wdata(rmw_wdata),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_selected(rsp_selected),
      .pins(pins), .dout(dout));
   drmc_mem_model u_drmc_mem_model (.pins(pins), .dout(dout));
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   always @(negedge pins.ras_n) n_ras++;
   task automatic check(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %b want %b", $time, got, exp);
      end
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic access(input drmc_pkg::drmc_op_t op, input logic [11:0] a,
                         input logic wd, input logic cs, output logic d, output logic s);
      int n;
      n = 0;
      req = '{op: op, addr: a, wdata: wd, cs_n: cs};
      rmw_wdata = wd;
      req_valid = 1'b1;
      while (req_ready !== 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 400) check(1'b0, 1'b1);
      d = rsp_data;
      s = rsp_selected;
   endtask
   task automatic t_write_read;
      logic        d;
      logic        s;
      logic [11:0] a [3] = '{12'h000, 12'hFFF, 12'h5A3};
      for (int i = 0; i < 3; i++) begin
         access(WR, a[i], i[0], 1'b0, d, s);
         check(d, 1'b1);
         check(s, 1'b1);
      end
      for (int i = 0; i < 3; i++) begin
         access(RD, a[i], 1'b0, 1'b0, d, s);
         check(d, i[0]);
      end
      $display("write and read done");
   endtask
   task automatic t_rmw;
      logic d;
      logic s;
      access(RM, 12'h5A3, 1'b1, 1'b0, d, s);
      check(d, 1'b0);
      access(RD, 12'h5A3, 1'b0, 1'b0, d, s);
      check(d, 1'b1);
      $display("rmw done");
   endtask
   task automatic t_desel;
      logic d;
      logic s;
      access(WR, 12'hFFF, 1'b0, 1'b1, d, s);
      check(s, 1'b0);
      access(RD, 12'hFFF, 1'b0, 1'b1, d, s);
      check(s, 1'b0);
      access(RD, 12'hFFF, 1'b0, 1'b0, d, s);
      check(d, 1'b1);
      $display("deselect done");
   endtask
   task automatic t_refresh;
      logic d;
      logic s;
      int   n0;
      for (int r = 0; r < 64; r++) begin
         access(WR, {r[5:0], 6'h00}, 1'b1, 1'b0, d, s);
      end
      n0 = n_ras;
      repeat (200) @(negedge core_clk);
      check(n_ras - n0 >= 3, 1'b1);
      for (int r = 0; r < 64; r++) begin
         access(RD, {r[5:0], 6'h00}, 1'b0, 1'b0, d, s);
         check(d, 1'b1);
      end
      $display("refresh done");
   endtask
   initial begin
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      rmw_wdata = 1'b0;
      repeat (5) @(negedge core_clk);
      rst = 1'b0;
      t_write_read();
      t_rmw();
      t_desel();
      t_refresh();
      stop_test();
   end
   initial begin
      #(20000 * 50);
      check(1'b0, 1'b1);
      stop_test();
   end
endmodule
